// ===== pkg/conv_ctrl_pkg.sv
// Constants and carrier types for the conversion sequencing and input selection control.
// Assumes a single 20 MHz core clock shared with the serial-interface logic and the filter.
`default_nettype none

package conv_ctrl_pkg;

    // ****************************************
    // Clock and pacing
    // ****************************************

    // Core clock rate in hertz.
    localparam int unsigned CLK_HZ = 20_000_000;
    // Data rates in samples per second, indexed by the rate field; the top code repeats.
    localparam int unsigned RATE_SPS [8] = '{128, 250, 490, 920, 1600, 2400, 3300, 3300};
    // Width of the conversion period counter; the slowest rate needs 156250 cycles.
    localparam int unsigned CNT_W = 18;

    // ****************************************
    // Configuration and result layout
    // ****************************************

    // Configuration word as written and read back over the serial interface.
    typedef struct packed {
        logic start;        // Request one conversion (single-shot mode).
        logic mode_single;  // High for single-shot, low for continuous.
        logic [2:0] mux;    // Input combination code.
        logic [2:0] rate;   // Data rate code.
    } cfg_s;

    // Value after power-on or general-call reset.
    localparam cfg_s CFG_DEFAULT = '{start: 1'b0, mode_single: 1'b1, mux: 3'h0, rate: 3'h4};

    // Input-selection switch drive, one-hot per side.
    typedef struct packed {
        logic [3:0] pos;    // Channel 0..3 onto the positive converter input.
        logic [3:0] neg;    // Channel 0..3 onto the negative converter input.
        logic neg_gnd;      // Ground switch onto the negative converter input.
    } mux_sel_s;

    // Multiplexer codes; codes with bit 2 set are single-ended.
    localparam logic [2:0] MUX_CH0_CH1 = 3'h0;
    localparam logic [2:0] MUX_CH0_CH3 = 3'h1;
    localparam logic [2:0] MUX_CH1_CH3 = 3'h2;
    localparam logic [2:0] MUX_CH2_CH3 = 3'h3;
    localparam int unsigned MUX_SE_BIT = 2;

    // Result codes: left-aligned 12-bit two's complement in a 16-bit word.
    localparam logic signed [15:0] CODE_POS_FS = 16'sh7ff0;
    localparam logic signed [15:0] CODE_NEG_FS = 16'sh8000;
    localparam logic [15:0] RESULT_RESET = 16'h0000;
    localparam int unsigned RESULT_PAD = 4;

    // Period in core cycles for one rate code.
    function automatic int unsigned conv_cycles(input int unsigned code);
        return CLK_HZ / RATE_SPS[code];
    endfunction : conv_cycles

endpackage : conv_ctrl_pkg

`default_nettype wire

// ===== src/conv_ctrl.sv
// Conversion sequencing, result holding and input-multiplexer drive for a 12-bit converter.
// Assumes the serial-interface logic, the general-call decoder and the digital filter all
// run on core_clk, so their strobes and data need no synchroniser.
//
// What this block does
// - Single-shot request yields exactly one conversion
// - After single-shot, enter shutdown until requested
// - Continuous mode restarts conversion immediately on completion
// - Continuous results paced by programmed data rate
// - Result holds last completed conversion, cleared by reset
// - Select four single-ended or two differential inputs
// - Offer channel 0 and 1 against channel 3
// - Three-bit field picks each input combination
// - Single-ended grounds the negative converter input
// - Results carry 12-bit resolution
// - Single-ended results never use negative codes
// - Left-aligned codes clip at 7ff0 and 8000
// - General-call reset restores power-on defaults
`default_nettype none

module conv_ctrl
    import conv_ctrl_pkg::*;
#(
    // Conversion period in cycles per rate code; shorten for simulation.
    parameter int unsigned CONV_CYCLES [8] = '{conv_cycles(0), conv_cycles(1), conv_cycles(2),
        conv_cycles(3), conv_cycles(4), conv_cycles(5), conv_cycles(6), conv_cycles(7)}
) (
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic cfg_wr,
    input wire conv_ctrl_pkg::cfg_s cfg_in,
    input wire logic gc_reset,
    input wire logic signed [15:0] filt_data,
    output conv_ctrl_pkg::cfg_s cfg_out,
    output logic [15:0] result,
    output logic conv_start,
    output logic conv_done,
    output logic powered_down,
    output conv_ctrl_pkg::mux_sel_s mux_sel
);
    import conv_ctrl_pkg::*;

    // ****************************************
    // Local types and helpers
    // ****************************************

    // Sequencer states.
    typedef enum logic [0:0] {
        ST_OFF = 1'b0,   // Low-power shutdown, no conversion running.
        ST_CONV = 1'b1   // Conversion period counting.
    } conv_state_e;

    // Decode a multiplexer code into switch drive.
    function automatic mux_sel_s mux_decode(input logic [2:0] code);
        mux_sel_s sel;
        sel = '0;
        unique case (code)
            MUX_CH0_CH1: begin
                sel.pos = 4'h1;
                sel.neg = 4'h2;
            end
            MUX_CH0_CH3: begin
                sel.pos = 4'h1;
                sel.neg = 4'h8;
            end
            MUX_CH1_CH3: begin
                sel.pos = 4'h2;
                sel.neg = 4'h8;
            end
            MUX_CH2_CH3: begin
                sel.pos = 4'h4;
                sel.neg = 4'h8;
            end
            default: begin
                // Single-ended codes: channel from the low two bits, negative side grounded.
                sel.pos = 4'h1 << code[1:0];
                sel.neg_gnd = 1'b1;
            end
        endcase
        return sel;
    endfunction : mux_decode

    // Load value for the period counter; the count runs down to zero.
    function automatic logic [CNT_W-1:0] period_load(input logic [2:0] code);
        return CNT_W'(CONV_CYCLES[code] - 1);
    endfunction : period_load

    // Turn the filter output into a clipped, left-aligned 12-bit code.
    function automatic logic [15:0] clip_code(input logic signed [15:0] raw, input logic se);
        logic signed [15:0] v;
        v = raw;
        if (se && v < 0) begin
            v = '0;
        end else if (v > CODE_POS_FS) begin
            v = CODE_POS_FS;
        end
        // The most negative 16-bit value already equals the negative full-scale code.
        return {v[15:RESULT_PAD], {RESULT_PAD{1'b0}}};
    endfunction : clip_code

    // ****************************************
    // Registers and next-state terms
    // ****************************************

    conv_state_e state_ff;          // Sequencer state.
    conv_state_e nxt_state;         // Next sequencer state.
    cfg_s cfg_ff;                   // Stored configuration.
    logic [CNT_W-1:0] cnt_ff;       // Cycles left in the running conversion.
    logic [2:0] conv_mux_ff;        // Input code of the running conversion.
    logic [2:0] conv_rate_ff;       // Rate code of the running conversion.
    logic [15:0] result_ff;         // Last completed result.
    logic conv_start_ff;            // One-cycle start pulse to the filter.
    logic conv_done_ff;             // One-cycle completion pulse.
    logic powered_down_ff;          // Shutdown indication.
    mux_sel_s mux_sel_ff;           // Switch drive.
    logic start_req;                // A write that launches a conversion from shutdown.
    logic conv_end;                 // Last cycle of a running conversion.
    logic restart;                  // Back-to-back launch in continuous mode.
    logic launch;                   // Any launch.
    logic [2:0] launch_mux;         // Input code for a launch.
    logic [2:0] launch_rate;        // Rate code for a launch.

    // Launch and completion decode.
    always_comb begin
        // A single-shot request, or a write selecting continuous mode, wakes the converter.
        start_req = cfg_wr && (cfg_in.start || !cfg_in.mode_single) && state_ff == ST_OFF;
        conv_end = state_ff == ST_CONV && cnt_ff == '0;
        restart = conv_end && !cfg_ff.mode_single;
        launch = start_req || restart;
        launch_mux = start_req ? cfg_in.mux : cfg_ff.mux;
        launch_rate = start_req ? cfg_in.rate : cfg_ff.rate;
    end

    // Next sequencer state.
    always_comb begin
        nxt_state = state_ff;
        unique case (state_ff)
            ST_OFF: begin
                if (start_req) begin
                    nxt_state = ST_CONV;
                end
            end
            ST_CONV: begin
                if (conv_end && cfg_ff.mode_single) begin
                    nxt_state = ST_OFF;
                end
            end
        endcase
    end

    // ****************************************
    // Sequencer
    // ****************************************

    // State; a general-call reset acts exactly like the power-on reset.
    always_ff @(posedge core_clk) begin
        if (!nrst || gc_reset) begin
            state_ff <= ST_OFF;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // Configuration store. The start bit is not kept: it is a request, not a setting.
    // The input and rate codes of a write during a conversion only take effect at the next launch, so the running
    // conversion keeps a consistent input and period; a new mode_single applies at the running conversion's end.
    always_ff @(posedge core_clk) begin
        if (!nrst || gc_reset) begin
            cfg_ff <= CFG_DEFAULT;
        end else if (cfg_wr) begin
            cfg_ff <= '{start: 1'b0, mode_single: cfg_in.mode_single, mux: cfg_in.mux,
                        rate: cfg_in.rate};
        end
    end

    // Period counter, loaded from the rate code captured at each launch.
    always_ff @(posedge core_clk) begin
        if (!nrst || gc_reset) begin
            cnt_ff <= '0;
        end else if (launch) begin
            cnt_ff <= period_load(launch_rate);
        end else if (state_ff == ST_CONV && cnt_ff != '0) begin
            cnt_ff <= cnt_ff - 1'b1;
        end
    end

    // Per-conversion input and rate codes, plus the switch drive.
    always_ff @(posedge core_clk) begin
        if (!nrst || gc_reset) begin
            conv_mux_ff <= CFG_DEFAULT.mux;
            conv_rate_ff <= CFG_DEFAULT.rate;
            mux_sel_ff <= mux_decode(CFG_DEFAULT.mux);
        end else if (launch) begin
            conv_mux_ff <= launch_mux;
            conv_rate_ff <= launch_rate;
            mux_sel_ff <= mux_decode(launch_mux);
        end
    end

    // ****************************************
    // Result and status
    // ****************************************

    // Outside reset, the result changes only when a conversion completes, so any read sees a whole one.
    always_ff @(posedge core_clk) begin
        if (!nrst || gc_reset) begin
            result_ff <= RESULT_RESET;
        end else if (conv_end) begin
            result_ff <= clip_code(filt_data, conv_mux_ff[MUX_SE_BIT]);
        end
    end

    // Pulses and shutdown flag.
    always_ff @(posedge core_clk) begin
        if (!nrst || gc_reset) begin
            conv_start_ff <= 1'b0;
            conv_done_ff <= 1'b0;
            powered_down_ff <= 1'b1;
        end else begin
            conv_start_ff <= launch;
            conv_done_ff <= conv_end;
            powered_down_ff <= nxt_state == ST_OFF;
        end
    end

    assign cfg_out = cfg_ff;
    assign result = result_ff;
    assign conv_start = conv_start_ff;
    assign conv_done = conv_done_ff;
    assign powered_down = powered_down_ff;
    assign mux_sel = mux_sel_ff;

    // ****************************************
    // Assertions
    // ****************************************

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!nrst || gc_reset);

    // Cycles since the last start pulse; read only by the checks.
    logic [CNT_W:0] elapsed_ff;
    always_ff @(posedge core_clk) begin
        if (!nrst || gc_reset) begin
            elapsed_ff <= '0;
        end else if (conv_start_ff) begin
            elapsed_ff <= (CNT_W + 1)'(1);
        end else if (elapsed_ff != '1) begin
            elapsed_ff <= elapsed_ff + 1'b1;
        end
    end

    // A completion that was in single-shot mode.
    sequence single_finish;
        conv_done && $past(cfg_ff.mode_single);
    endsequence
    // A completion that was in continuous mode.
    sequence cont_finish;
        conv_done && !$past(cfg_ff.mode_single);
    endsequence

    // A new request may follow the completion at once, so one cycle later the block is
    // either still down or has just launched, never awake without a launch.
    property finish_then_off;
        single_finish |-> powered_down && !conv_start ##1 (powered_down != conv_start);
    endproperty

    one_shot_a: assert property (single_finish |-> !conv_start)
        else $error("single-shot completion relaunched");
    shutdown_after_a: assert property (finish_then_off)
        else $error("no shutdown after single-shot conversion");
    cont_restart_a: assert property (cont_finish |-> conv_start && !powered_down)
        else $error("continuous conversion did not restart");
    // The rate code is taken one cycle back, since a relaunch reloads it with the done pulse.
    rate_period_a: assert property (conv_done && elapsed_ff != '1
        |-> elapsed_ff == (CNT_W + 1)'(CONV_CYCLES[$past(conv_rate_ff)]))
        else $error("conversion period differs from data rate");
    // A reset also clears the result; that step is legal in the cycle after it.
    result_hold_a: assert property ($changed(result)
        |-> conv_done || !$past(nrst) || $past(gc_reset))
        else $error("result changed outside completion");
    pos_onehot_a: assert property ($onehot(mux_sel.pos))
        else $error("positive selection not one-hot");
    ch3_pair_a: assert property (conv_start && conv_mux_ff == MUX_CH1_CH3
        |-> mux_sel.pos == 4'h2 && mux_sel.neg == 4'h8)
        else $error("channel 1 against 3 decoded wrongly");
    mux_field_a: assert property (conv_start |-> mux_sel == mux_decode(conv_mux_ff))
        else $error("switch drive does not follow the code");
    gnd_switch_a: assert property (mux_sel.neg_gnd == conv_mux_ff[MUX_SE_BIT]
        && (!mux_sel.neg_gnd || mux_sel.neg == 4'h0))
        else $error("ground switch wrong for selection");
    low_nibble_a: assert property (result[RESULT_PAD-1:0] == 4'h0)
        else $error("result not left-aligned");
    se_positive_a: assert property (conv_done && $past(conv_mux_ff[MUX_SE_BIT])
        |-> !result[15])
        else $error("single-ended result negative");
    clip_top_a: assert property (conv_done && $past(filt_data) > CODE_POS_FS
        |-> result == CODE_POS_FS)
        else $error("positive clip code wrong");
    gc_default_a: assert property (@(posedge core_clk) disable iff (!nrst)
        gc_reset |=> cfg_out == CFG_DEFAULT && powered_down && !conv_done)
        else $error("general-call reset did not restore defaults");

endmodule : conv_ctrl

`default_nettype wire

// ===== testbench/host_model.sv
// Behavioural host that configures the converter control over its write strobe.
// Assumes it shares core_clk with the bench and is called from one process only.
`default_nettype none

module host_model
    import conv_ctrl_pkg::*;
(
    input wire logic core_clk,
    output logic cfg_wr,
    output conv_ctrl_pkg::cfg_s cfg_in
);
    timeunit 1ns;
    timeprecision 1ps;

    // Quiet bus at time zero.
    initial begin
        cfg_wr = 1'b0;
        cfg_in = '0;
    end

    // One write, driven on a falling edge and held over the rising edge that takes it.
    // The task does not wait for conv_done before the result is trusted; the bench does that.
    task automatic write_cfg(input logic st, input logic sg, input logic [2:0] mx,
                             input logic [2:0] rt);
        @(negedge core_clk);
        cfg_wr <= 1'b1;
        cfg_in <= '{start: st, mode_single: sg, mux: mx, rate: rt};
        @(negedge core_clk);
        cfg_wr <= 1'b0;
        cfg_in <= ~cfg_in; // Released data must not keep looking valid.
    endtask : write_cfg
endmodule : host_model

`default_nettype wire

// ===== testbench/adc_conversion_mode_mux_control_tb.sv
// Self-checking bench for the conversion sequencing and input selection control.
// Assumes shortened conversion periods; the filter is played by the bench itself.
`default_nettype none

module adc_conversion_mode_mux_control_tb;
    import conv_ctrl_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;

    // ****************************************
    // Signals and bookkeeping
    // ****************************************
    localparam int unsigned CYC [8] = '{40, 30, 20, 12, 8, 5, 3, 3}; // Short periods.
    logic core_clk, nrst, gc_reset, cfg_wr, conv_start, conv_done, powered_down;
    logic signed [15:0] filt_data;
    logic [15:0] result;
    logic [15:0] last_res; // Last result seen with conv_done.
    logic [15:0] exp_q[$]; // Expected codes, one per launch.
    logic [2:0] tb_mux; // Mux code the bench believes is active.
    cfg_s cfg_in, cfg_out;
    mux_sel_s mux_sel;
    int n_errors = 0;
    int comparisons = 0;
    int tick = 0;
    int n_launch = 0;
    int cyc;

    conv_ctrl #(.CONV_CYCLES(CYC)) i_conv_ctrl (.core_clk(core_clk), .nrst(nrst),
        .cfg_wr(cfg_wr), .cfg_in(cfg_in), .gc_reset(gc_reset), .filt_data(filt_data),
        .cfg_out(cfg_out), .result(result), .conv_start(conv_start), .conv_done(conv_done),
        .powered_down(powered_down), .mux_sel(mux_sel));
    host_model i_host_model (.core_clk(core_clk), .cfg_wr(cfg_wr), .cfg_in(cfg_in));

    // Free-running 20 MHz clock.
    initial begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end

    // ****************************************
    // Helpers
    // ****************************************
    task automatic check(input logic ok, input string what);
        comparisons++;
        if (!ok) begin
            n_errors++;
            $display("BAD %0t %s", $time, what);
        end
    endtask : check

    task automatic summarize();
        if (n_errors == 0 && comparisons > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : summarize

    // Expected code: clip high, floor single-ended negatives, keep 12 bits left-aligned.
    function automatic logic [15:0] expect_code(input logic signed [15:0] raw, input logic se);
        logic signed [15:0] v;
        v = raw;
        if (v > CODE_POS_FS) v = CODE_POS_FS;
        if (se && v < 0) v = 16'sh0000;
        return {v[15:4], 4'h0};
    endfunction : expect_code

    // Switch drive for a mux code; differential codes pair channel 0, 0, 1, 2 with 1, 3, 3, 3.
    function automatic mux_sel_s mux_exp(input logic [2:0] c);
        mux_sel_s s;
        s.pos = 4'h1 << (c[2] ? c[1:0] : (c == MUX_CH0_CH1 ? 2'h0 : 2'(c - 3'h1)));
        s.neg = c[2] ? 4'h0 : (c == MUX_CH0_CH1 ? 4'h2 : 4'h8);
        s.neg_gnd = c[2];
        return s;
    endfunction : mux_exp

    // Counts falling edges up to the next conv_done, at least one, so a call made in a
    // done cycle measures the following period. Bounded so a hang cannot stall the run.
    task automatic wait_done(input int limit, output int n);
        n = 0;
        do begin
            @(negedge core_clk);
            n++;
        end while (conv_done !== 1'b1 && n < limit);
    endtask : wait_done

    // ****************************************
    // Filter stand-in and result watcher
    // ****************************************
    // Pops before it pushes, since in continuous mode done and the next launch coincide.
    // A new filter value is held for the whole conversion, so the sample point cannot matter.
    always @(negedge core_clk) begin : watch
        logic signed [15:0] raw;
        if (!nrst || gc_reset) begin
            last_res = RESULT_RESET;
            exp_q.delete();
        end else begin
            if (conv_done === 1'b1) begin
                if (exp_q.size() == 0) check(1'b0, "result without launch");
                else check(result === exp_q.pop_front(), "result code");
                last_res = result;
            end else begin
                check(result === last_res, "result moved between conversions");
            end
            if (conv_start === 1'b1) begin
                case (n_launch % 4)
                    0: raw = 16'sh7ff9;
                    1: raw = 16'sh8000;
                    default: raw = 16'($urandom());
                endcase
                n_launch++;
                filt_data <= raw;
                exp_q.push_back(expect_code(raw, tb_mux[MUX_SE_BIT]));
            end
        end
    end

    // Hang guard; the whole sequence needs well under 2000 cycles.
    always @(posedge core_clk) begin
        tick++;
        if (tick == 20000) begin
            n_errors++;
            summarize();
        end
    end

    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        void'($urandom(78865));
        nrst = 1'b0;
        gc_reset = 1'b0;
        filt_data = '0;
        tb_mux = '0;
        repeat (12) @(negedge core_clk);
        nrst <= 1'b1;
        check(cfg_out === CFG_DEFAULT && powered_down === 1'b1, "reset state");
        check(mux_sel === mux_exp(3'h0) && result === RESULT_RESET, "reset drive");
        // Every mux code with a single-shot launch, each at its own rate.
        for (int m = 0; m < 8; m++) begin
            tb_mux = 3'(m);
            i_host_model.write_cfg(1'b1, 1'b1, 3'(m), 3'(m));
            check(conv_start === 1'b1 && powered_down === 1'b0, "launch");
            check(cfg_out === cfg_s'{1'b0, 1'b1, 3'(m), 3'(m)}, "config stored");
            check(mux_sel === mux_exp(3'(m)), "mux drive");
            wait_done(100, cyc);
            check(cyc == CYC[m], "conversion length");
            check(powered_down === 1'b1, "shutdown after single");
            repeat (3) begin
                @(negedge core_clk);
                check(conv_start === 1'b0 && powered_down === 1'b1, "stays idle");
            end
        end
        // A second request during a running conversion is ignored.
        tb_mux = 3'h1;
        i_host_model.write_cfg(1'b1, 1'b1, 3'h1, 3'h0);
        i_host_model.write_cfg(1'b1, 1'b1, 3'h1, 3'h0);
        check(conv_start === 1'b0, "no relaunch while busy");
        wait_done(100, cyc);
        repeat (45) @(negedge core_clk);
        check(powered_down === 1'b1 && exp_q.size() == 0, "one conversion only");
        // Continuous mode: back-to-back launches at the programmed period.
        tb_mux = 3'h5;
        i_host_model.write_cfg(1'b0, 1'b0, 3'h5, 3'h2);
        check(conv_start === 1'b1, "continuous launch");
        repeat (3) begin
            wait_done(100, cyc);
            check(cyc == CYC[2], "continuous period");
            check(conv_start === 1'b1 && powered_down === 1'b0, "immediate relaunch");
        end
        i_host_model.write_cfg(1'b0, 1'b1, 3'h5, 3'h2);
        wait_done(100, cyc);
        @(negedge core_clk);
        check(powered_down === 1'b1 && conv_start === 1'b0, "back to shutdown");
        // General-call reset in mid-conversion.
        tb_mux = 3'h0;
        i_host_model.write_cfg(1'b1, 1'b1, 3'h0, 3'h0);
        repeat (5) @(negedge core_clk);
        gc_reset <= 1'b1;
        @(negedge core_clk);
        gc_reset <= 1'b0;
        check(cfg_out === CFG_DEFAULT && powered_down === 1'b1, "general reset");
        check(result === RESULT_RESET, "general reset result");
        @(negedge core_clk);
        wait_done(50, cyc);
        check(cyc == 50, "aborted conversion stays silent");
        summarize();
    end
endmodule : adc_conversion_mode_mux_control_tb

`default_nettype wire
